/* exs_pkg.sv */
// shared constants and carriers for the exception syndrome field block
package exs_pkg;

    // syndrome bit n (0 = most significant) sits at vector index 31-n
    localparam int EXS_WIDTH = 32;
    localparam int EXS_FP_POS = 31 - 7;
    localparam int EXS_STORE_POS = 31 - 8;
    localparam int EXS_LOCK_HI = 31 - 10;
    localparam int EXS_LOCK_LO = 31 - 11;
    localparam int EXS_AUX_POS = 31 - 12;
    localparam int EXS_UNIMPL_POS = 31 - 13;
    localparam int EXS_BYTE_POS = 31 - 14;
    localparam int EXS_IMPR_POS = 31 - 15;
    localparam int EXS_CRU_POS = 31 - 27;
    localparam int EXS_CMP_POS = 31 - 28;
    localparam int EXS_CRF_HI = 31 - 29;
    localparam int EXS_CRF_LO = 31 - 31;

    // bits that hold storage; bit 9 and bits 16..26 are reserved and absent
    localparam logic [31:0] EXS_IMPL_MASK = 32'hFFBF001F;
    localparam logic [31:0] EXS_RESET = 32'h00000000;
    localparam logic [31:0] EXS_ADDR_RESET = 32'h00000000;

    // lock_fault_source encodings
    localparam logic [1:0] EXS_LOCK_NONE = 2'h0;
    localparam logic [1:0] EXS_LOCK_FLUSH = 2'h1;
    localparam logic [1:0] EXS_LOCK_INVAL = 2'h2;

    // one exception report from the pipeline and floating-point unit
    typedef struct packed {
        logic take;          // syndrome-reporting interrupt taken this cycle
        logic fp_op;
        logic store;
        logic [1:0] lock_src;
        logic aux;
        logic unimpl;
        logic byte_order;
        logic fp_enabled;    // floating-point-enabled program interrupt
        logic cr_update;
        logic fp_compare;
        logic [2:0] cr_field;
        logic [31:0] fault_addr;
        logic [31:0] next_addr;
    } exs_cause_t;

    // software move-to / move-from port of the syndrome register
    typedef struct packed {
        logic wr;
        logic [31:0] wdata;
    } exs_spr_t;

endpackage : exs_pkg

/* exs_impr_det.sv */
// watches the float exception mode for an imprecise enabled exception
`timescale 1ns/100ps
module exs_impr_det
    import exs_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [1:0] float_exc_mode_i,
    input wire logic float_enabled_summary_i,
    input wire logic consume_i,
    output logic imprecise_o
);

    logic [1:0] mode_q;
    logic summary_q;
    logic arm;

    // previous mode and summary, to see the mode leave zero
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            mode_q <= 2'h0;
            summary_q <= 1'b0;
        end else begin
            mode_q <= float_exc_mode_i;
            summary_q <= float_enabled_summary_i;
        end
    end

    // summary must already be high before the mode turns on
    assign arm = (mode_q == 2'h0) && (float_exc_mode_i != 2'h0) && summary_q;

    // sticky until the interrupt consumes it; a new arm wins over consume
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            imprecise_o <= 1'b0;
        end else if (arm) begin
            imprecise_o <= 1'b1;
        end else if (consume_i) begin
            imprecise_o <= 1'b0;
        end
    end

    a_arm_sets: assert property (@(posedge clock_i) disable iff (reset_i)
        arm |=> imprecise_o)
        else $error("imprecise not armed");

endmodule : exs_impr_det

/* exs_syndrome.sv */
// exception syndrome register, fields in bits 7..15 and 27..31, and saved return address
// Contract
// - set float op bit for float faults
// - set write bit for store faults
// - lock source 00 none 01 flush 10 invalidate
// - set aux bit for auxiliary faults
// - set unimplemented bit for unimplemented ops
// - set byte order bit on byte faults
// - imprecise selects later address in save register
// - imprecise only when mode enabled after summary
// - set cr update for cr-updating float faults
// - set compare bit for float compares
// - cr fields defined only precise float enabled
// - cr field index gets target field number
// - update sets cause bits, clears others
// - other interrupts leave register unchanged
`timescale 1ns/100ps
module exs_syndrome
    import exs_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire exs_cause_t cause_i,
    input wire exs_spr_t spr_i,
    input wire logic [1:0] float_exc_mode_i,
    input wire logic float_enabled_summary_i,
    output logic [31:0] exception_syndrome_o,
    output logic [31:0] save_restore_addr0_o
);

    logic [31:0] syn_q;
    logic [31:0] syn_d;
    logic [31:0] ret_addr_q;
    logic impr_pend;
    logic impr;
    logic cr_valid;

    // consumed by any float-enabled program interrupt taken
    // kept in its own module so the arm/consume race is settled in one place
    exs_impr_det u_exs_impr_det (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .float_exc_mode_i(float_exc_mode_i),
        .float_enabled_summary_i(float_enabled_summary_i),
        .consume_i(cause_i.take && cause_i.fp_enabled),
        .imprecise_o(impr_pend)
    );

    // reserved lock code from a report never reaches the register
    function automatic logic [1:0] lock_code(input logic [1:0] src);
        lock_code = (src == 2'h3) ? EXS_LOCK_NONE : src;
    endfunction : lock_code

    assign impr = cause_i.fp_enabled && impr_pend;
    assign cr_valid = cause_i.fp_enabled && !impr;

    // fresh syndrome built from zero so stale bits never survive
    always_comb begin
        syn_d = 32'h00000000;
        syn_d[EXS_FP_POS] = cause_i.fp_op;
        syn_d[EXS_STORE_POS] = cause_i.store;
        syn_d[EXS_LOCK_HI:EXS_LOCK_LO] = lock_code(cause_i.lock_src);
        syn_d[EXS_AUX_POS] = cause_i.aux;
        syn_d[EXS_UNIMPL_POS] = cause_i.unimpl;
        syn_d[EXS_BYTE_POS] = cause_i.byte_order;
        syn_d[EXS_IMPR_POS] = impr;
        // outside the defined case these read as zero rather than leftovers
        syn_d[EXS_CRU_POS] = cr_valid && cause_i.cr_update;
        syn_d[EXS_CMP_POS] = cr_valid && cause_i.fp_compare;
        if (cr_valid && cause_i.cr_update) begin
            syn_d[EXS_CRF_HI:EXS_CRF_LO] = cause_i.cr_field;
        end
    end

    // hardware update wins over a software write in the same cycle
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            syn_q <= EXS_RESET;
        end else if (cause_i.take) begin
            syn_q <= syn_d & EXS_IMPL_MASK;
        end else if (spr_i.wr) begin
            syn_q <= spr_i.wdata & EXS_IMPL_MASK;
        end
    end

    // return address follows the precision of the report
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ret_addr_q <= EXS_ADDR_RESET;
        end else if (cause_i.take) begin
            // the pipeline offers both addresses; only the precision picks one
            ret_addr_q <= impr ? cause_i.next_addr : cause_i.fault_addr;
        end
    end

    assign exception_syndrome_o = syn_q;
    assign save_restore_addr0_o = ret_addr_q;

    // report taken that does not consume a pending imprecise exception
    sequence s_take_precise;
        cause_i.take && !impr;
    endsequence

    // report taken that consumes a pending imprecise exception
    sequence s_take_impr;
        cause_i.take && impr;
    endsequence

    // float-enabled program interrupt reported precisely: cr fields are defined
    sequence s_take_fe_precise;
        cause_i.take && cause_i.fp_enabled && !impr;
    endsequence

    // report other than a float-enabled program interrupt: cr fields carry no meaning and must read zero
    sequence s_take_other;
        cause_i.take && !cause_i.fp_enabled;
    endsequence

    // single cause bits follow the report one cycle later
    a_fp_bit: assert property (@(posedge clock_i) disable iff (reset_i)
        cause_i.take |=> syn_q[EXS_FP_POS] == $past(cause_i.fp_op))
        else $error("float op bit wrong");

    a_store_bit: assert property (@(posedge clock_i) disable iff (reset_i)
        cause_i.take |=> syn_q[EXS_STORE_POS] == $past(cause_i.store))
        else $error("write access bit wrong");

    // lock source: reserved code never stored by a report, other codes pass through
    a_lock_code: assert property (@(posedge clock_i) disable iff (reset_i)
        syn_q[EXS_LOCK_HI:EXS_LOCK_LO] != 2'h3 || !$past(cause_i.take))
        else $error("reserved lock code produced");

    a_lock_pass: assert property (@(posedge clock_i) disable iff (reset_i)
        cause_i.take && cause_i.lock_src != 2'h3 |=>
        syn_q[EXS_LOCK_HI:EXS_LOCK_LO] == $past(cause_i.lock_src))
        else $error("lock source field wrong");

    a_lock_resv_src: assert property (@(posedge clock_i) disable iff (reset_i)
        cause_i.take && cause_i.lock_src == 2'h3 |=>
        syn_q[EXS_LOCK_HI:EXS_LOCK_LO] == EXS_LOCK_NONE)
        else $error("reserved lock source not mapped to none");

    a_aux_bit: assert property (@(posedge clock_i) disable iff (reset_i)
        cause_i.take |=> syn_q[EXS_AUX_POS] == $past(cause_i.aux))
        else $error("aux bit wrong");

    a_unimpl_bit: assert property (@(posedge clock_i) disable iff (reset_i)
        cause_i.take |=> syn_q[EXS_UNIMPL_POS] == $past(cause_i.unimpl))
        else $error("unimplemented bit wrong");

    a_byte_bit: assert property (@(posedge clock_i) disable iff (reset_i)
        cause_i.take |=> syn_q[EXS_BYTE_POS] == $past(cause_i.byte_order))
        else $error("byte order bit wrong");

    // return address: fault address when precise, later address when not
    a_ret_precise: assert property (@(posedge clock_i) disable iff (reset_i)
        s_take_precise |=> ret_addr_q == $past(cause_i.fault_addr))
        else $error("precise return address wrong");

    a_ret_impr: assert property (@(posedge clock_i) disable iff (reset_i)
        s_take_impr |=> ret_addr_q == $past(cause_i.next_addr) && syn_q[EXS_IMPR_POS])
        else $error("imprecise return address wrong");

    // imprecise bit only for an enabled float interrupt with a pending arm
    a_impr_only_fe: assert property (@(posedge clock_i) disable iff (reset_i)
        cause_i.take && !cause_i.fp_enabled |=> !syn_q[EXS_IMPR_POS])
        else $error("imprecise set outside enabled case");

    a_impr_needs_pend: assert property (@(posedge clock_i) disable iff (reset_i)
        cause_i.take && !impr_pend |=> !syn_q[EXS_IMPR_POS])
        else $error("imprecise set with nothing pending");

    // cr bits defined only for a precise float-enabled program interrupt
    a_cru_bit: assert property (@(posedge clock_i) disable iff (reset_i)
        s_take_fe_precise |=> syn_q[EXS_CRU_POS] == $past(cause_i.cr_update))
        else $error("cr update bit wrong");

    a_cmp_bit: assert property (@(posedge clock_i) disable iff (reset_i)
        s_take_precise and cause_i.fp_enabled |=>
        syn_q[EXS_CMP_POS] == $past(cause_i.fp_compare))
        else $error("compare bit wrong");

    a_cr_impr_zero: assert property (@(posedge clock_i) disable iff (reset_i)
        s_take_impr |=> !syn_q[EXS_CRU_POS] && !syn_q[EXS_CMP_POS])
        else $error("cr bits set while imprecise");

    a_cr_other_zero: assert property (@(posedge clock_i) disable iff (reset_i)
        s_take_other |=> syn_q[EXS_CRU_POS:EXS_CRF_LO] == 5'h00)
        else $error("cr bits set outside enabled case");

    a_cr_defined: assert property (@(posedge clock_i) disable iff (reset_i)
        s_take_precise and (cause_i.fp_enabled && cause_i.cr_update) |=>
        syn_q[EXS_CRU_POS] && syn_q[EXS_CRF_HI:EXS_CRF_LO] == $past(cause_i.cr_field))
        else $error("cr field not loaded");

    a_crf_no_update: assert property (@(posedge clock_i) disable iff (reset_i)
        s_take_fe_precise and !cause_i.cr_update |=>
        syn_q[EXS_CRF_HI:EXS_CRF_LO] == 3'h0)
        else $error("cr field loaded without update");

    // stale bits cleared by a report, everything kept without one or a software write
    a_low_cleared: assert property (@(posedge clock_i) disable iff (reset_i)
        cause_i.take |=> syn_q[31:25] == 7'h00)
        else $error("stale low bits survived");

    a_hold: assert property (@(posedge clock_i) disable iff (reset_i)
        !cause_i.take && !spr_i.wr |=> $stable(syn_q))
        else $error("syndrome changed without cause");

    a_ret_hold: assert property (@(posedge clock_i) disable iff (reset_i)
        !cause_i.take |=> $stable(ret_addr_q))
        else $error("return address changed without report");

    // reserved bits stay zero whoever writes the register
    a_reserved: assert property (@(posedge clock_i) disable iff (reset_i)
        (syn_q & ~EXS_IMPL_MASK) == 32'h00000000)
        else $error("reserved bit set");

    a_sw_write: assert property (@(posedge clock_i) disable iff (reset_i)
        !cause_i.take && spr_i.wr |=> syn_q == ($past(spr_i.wdata) & EXS_IMPL_MASK))
        else $error("software write not stored through mask");

endmodule : exs_syndrome

/* exs_pipe_model.sv */
// pipeline and float unit model that reports exception causes
`timescale 1ns/100ps
module exs_pipe_model
    import exs_pkg::*;
(
    input wire logic clock_i,
    output exs_cause_t cause_o,
    output logic [1:0] float_exc_mode_o,
    output logic float_enabled_summary_o
);
    // quiet start: no report, float exceptions disabled
    initial begin
        cause_o = '0;
        float_exc_mode_o = 2'h0;
        float_enabled_summary_o = 1'b0;
    end
    // one-cycle report; afterwards the cause lines show the inverse, never stale data
    task automatic report(input exs_cause_t c);
        exs_cause_t t;
        t = c;
        t.take = 1'b1;
        @(negedge clock_i);
        cause_o = t;
        t = ~c;
        t.take = 1'b0;
        @(negedge clock_i);
        cause_o = t;
    endtask : report
    // summary already high when the mode turns non-zero: the imprecise case
    task automatic arm();
        @(negedge clock_i);
        float_enabled_summary_o = 1'b1;
        float_exc_mode_o = 2'h0;
        @(negedge clock_i);
        float_exc_mode_o = 2'h1;
    endtask : arm
endmodule : exs_pipe_model

/* exs_syndrome_tb.sv */
// self-checking bench for the exception syndrome block
`timescale 1ns/100ps
module exs_syndrome_tb
    import exs_pkg::*;
;
    logic clock_i;
    logic reset_i;
    exs_cause_t cause;
    exs_spr_t spr;
    logic [1:0] mode;
    logic summary;
    logic [31:0] syndrome;
    logic [31:0] ret_addr;
    exs_cause_t c;
    int n_fail = 0;
    int check_count = 0;
    exs_syndrome u_exs_syndrome (.clock_i(clock_i), .reset_i(reset_i), .cause_i(cause),
        .spr_i(spr), .float_exc_mode_i(mode), .float_enabled_summary_i(summary),
        .exception_syndrome_o(syndrome), .save_restore_addr0_o(ret_addr));
    exs_pipe_model u_exs_pipe_model (.clock_i(clock_i), .cause_o(cause),
        .float_exc_mode_o(mode), .float_enabled_summary_o(summary));
    // free-running core clock
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    // software move-to, one strobe cycle; data goes stale-free afterwards
    task automatic sw_write(input logic [31:0] v);
        @(negedge clock_i);
        spr = '{wr: 1'b1, wdata: v};
        @(negedge clock_i);
        spr = '{wr: 1'b0, wdata: ~v};
    endtask : sw_write
    // expected word built bit by bit from the field layout
    function automatic logic [31:0] exp_word(input exs_cause_t k, input logic impr);
        logic [31:0] w;
        w = '0;
        w[EXS_FP_POS] = k.fp_op;
        w[EXS_STORE_POS] = k.store;
        w[EXS_LOCK_HI:EXS_LOCK_LO] = (k.lock_src == 2'h3) ? 2'h0 : k.lock_src;
        w[EXS_AUX_POS] = k.aux;
        w[EXS_UNIMPL_POS] = k.unimpl;
        w[EXS_BYTE_POS] = k.byte_order;
        w[EXS_IMPR_POS] = impr;
        if (k.fp_enabled && !impr) begin
            w[EXS_CRU_POS] = k.cr_update;
            w[EXS_CMP_POS] = k.fp_compare;
            w[EXS_CRF_HI:EXS_CRF_LO] = k.cr_update ? k.cr_field : 3'h0;
        end
        return w;
    endfunction : exp_word
    task automatic take_chk(input exs_cause_t k, input logic impr);
        u_exs_pipe_model.report(k);
        chk("syndrome", exp_word(k, impr), syndrome);
        chk("save_restore_addr0", impr ? k.next_addr : k.fault_addr, ret_addr);
        // cause lines now show the inverse with no take: nothing may move
        @(negedge clock_i);
        chk("syndrome hold", exp_word(k, impr), syndrome);
        chk("save_restore_addr0 hold", impr ? k.next_addr : k.fault_addr, ret_addr);
    endtask : take_chk
    task automatic sc_flags();
        sw_write(32'hFFFFFFFF);
        chk("write mask", 32'hFFBF001F, syndrome);
        repeat (3) @(negedge clock_i);
        chk("idle hold", 32'hFFBF001F, syndrome);
        for (int i = 0; i < 8; i++) begin
            c = '0;
            c.fault_addr = 32'h00001000 + i;
            c.next_addr = 32'h00002000 + i;
            c.fp_op = (i == 0);
            c.store = (i == 1);
            c.aux = (i == 2);
            c.unimpl = (i == 3);
            c.byte_order = (i == 4);
            c.lock_src = (i > 4) ? 2'(i - 4) : 2'h0;
            take_chk(c, 1'b0);
        end
    endtask : sc_flags
    task automatic sc_float();
        c = '0;
        c.fp_op = 1'b1;
        c.fp_enabled = 1'b1;
        c.cr_update = 1'b1;
        c.fp_compare = 1'b1;
        c.cr_field = 3'h5;
        c.fault_addr = 32'h0000A000;
        c.next_addr = 32'h0000A004;
        take_chk(c, 1'b0);
        c.cr_update = 1'b0;
        take_chk(c, 1'b0);
        c.cr_update = 1'b1;
        c.fp_enabled = 1'b0;
        take_chk(c, 1'b0);
        c.fp_enabled = 1'b1;
        u_exs_pipe_model.arm();
        take_chk(c, 1'b1);
        take_chk(c, 1'b0);
    endtask : sc_float
    // cut a hang short
    initial begin
        #100000;
        n_fail++;
        give_verdict();
    end
    // main sequence
    initial begin
        reset_i = 1'b1;
        spr = '0;
        repeat (6) @(posedge clock_i);
        @(negedge clock_i);
        reset_i = 1'b0;
        chk("reset syndrome", 32'h00000000, syndrome);
        chk("reset save_restore_addr0", 32'h00000000, ret_addr);
        sc_flags();
        sc_float();
        give_verdict();
    end
endmodule : exs_syndrome_tb
